// [tsc_pkg.sv]
// Constants for the touch sensor configuration register bank
package tsc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_FILTER = 8'h56;
  localparam logic [7:0] OFS_SCAN0 = 8'h5c;
  localparam logic [7:0] OFS_SCAN1 = 8'h5d;
  localparam logic [7:0] OFS_THR0 = 8'h66;
  localparam logic [7:0] OFS_THR1 = 8'h67;
  localparam logic [7:0] OFS_CUR0 = 8'h70;
  localparam logic [7:0] OFS_CUR1 = 8'h71;
  localparam logic [7:0] OFS_GUARD = 8'h79;
  localparam logic [7:0] OFS_IDENT = 8'h7a;
  localparam logic [7:0] OFS_STATUS = 8'h7b;
  localparam logic [7:0] OFS_ADDRPU = 8'h7c;
  localparam logic [7:0] OFS_RBSEL = 8'h81;
  localparam logic [7:0] OFS_BASE_HI = 8'h82;
  localparam logic [7:0] OFS_BASE_LO = 8'h83;
  localparam logic [7:0] OFS_DELTA_HI = 8'h84;
  localparam logic [7:0] OFS_DELTA_LO = 8'h85;
  localparam logic [7:0] OFS_RAW_HI = 8'h86;
  localparam logic [7:0] OFS_RAW_LO = 8'h87;
  localparam logic [7:0] OFS_TOUCH = 8'h88;
  localparam logic [7:0] OFS_CMD = 8'ha0;

  // ****************************************
  // Reset values and field layout
  // ****************************************
  localparam logic [7:0] RST_FILTER = 8'h20;
  localparam logic [7:0] FILT_WR_MASK = 8'hb3;
  localparam int FILT_CLR_BIT = 7;
  localparam int FILT_DROP_BIT = 5;
  localparam int FILT_AVG_BIT = 4;
  localparam logic RST_SCAN0 = 1'b0;
  localparam logic RST_SCAN1 = 1'b1;
  localparam logic [7:0] RST_THR = 8'h64;
  localparam logic [7:0] RST_CUR = 8'h0a;
  localparam logic [7:0] CUR_ZERO_SUB = 8'h0a;
  localparam logic [7:0] RST_ADDRPU = 8'h00;
  localparam logic RST_LOCKED = 1'b0;
  localparam int RB_EN_BIT = 7;
  localparam int PULLUP_BIT = 7;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ****************************************
  // Commands and guard sequences
  // ****************************************
  localparam logic [7:0] CMD_SETUP = 8'h08;
  localparam logic [7:0] CMD_NORMAL = 8'h07;
  localparam logic [7:0] UNLOCK_B0 = 8'h3c;
  localparam logic [7:0] UNLOCK_B1 = 8'ha5;
  localparam logic [7:0] UNLOCK_B2 = 8'h69;
  localparam logic [7:0] LOCK_B0 = 8'h96;
  localparam logic [7:0] LOCK_B1 = 8'h5a;
  localparam logic [7:0] LOCK_B2 = 8'hc3;
  localparam logic [1:0] SEQ_LAST = 2'h2;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ****************************************
  // Serial slave states
  // ****************************************
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ACK_A = 7'h04,
    ST_WR = 7'h08,
    ST_ACK_W = 7'h10,
    ST_RD = 7'h20,
    ST_RACK = 7'h40
  } tsc_state_t;

endpackage

// [tsc_regs.sv]
// Touch sensor configuration register bank behind a serial two-wire slave
`timescale 1ns/1ps
`default_nettype none

module tsc_regs
  import tsc_pkg::*;
#(
  // Arbitrary neutral identity value
  parameter logic [7:0] PART_ID = 8'h5a
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [1:0] touch_input_mask,
  input wire logic [1:0][15:0] baseline_value,
  input wire logic [1:0][15:0] delta_count,
  input wire logic [1:0][15:0] raw_count,
  input wire logic [1:0] touch_detected,
  input wire logic [1:0] supply_range,
  input wire logic internal_reset_flag,
  input wire logic factory_config_loaded,
  input wire logic supply_too_low_for_store,
  input wire logic touch_function_on,
  input wire logic output_function_on,
  input wire logic scan_active,
  input wire logic scan_done,
  output logic sample_discard,
  output logic force_baseline_clear,
  output logic bus_busy_sample_drop,
  output logic avg_enable,
  output logic [1:0] avg_order,
  output logic scan_order_sensor0,
  output logic scan_order_sensor1,
  output logic [7:0] touch_threshold_sensor0,
  output logic [7:0] touch_threshold_sensor1,
  output logic [7:0] sense_current_sensor0,
  output logic [7:0] sense_current_sensor1,
  output logic [6:0] bus_address,
  output logic pullup_disable,
  output logic setup_mode,
  output logic bus_active
);

  // ****************************************
  // Pin synchronisers and bus conditions
  // ****************************************
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ****************************************
  // Register storage
  // ****************************************
  tsc_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txbyte;
  logic [7:0] ptr;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_stb;
  logic rw;
  logic first_byte;
  logic master_ack;
  logic [7:0] filter_ctrl;
  logic [1:0] unlock_stage;
  logic [1:0] lock_stage;
  logic bus_address_locked;
  logic [7:0] addr_pending;
  logic [2:0] readback_select;
  logic busy_seen;

  // ****************************************
  // Write decode
  // ****************************************
  wire wr_filter = wr_stb && (wr_addr == OFS_FILTER);
  wire wr_scan0 = wr_stb && (wr_addr == OFS_SCAN0) && setup_mode;
  wire wr_scan1 = wr_stb && (wr_addr == OFS_SCAN1) && setup_mode;
  wire wr_thr0 = wr_stb && (wr_addr == OFS_THR0);
  wire wr_thr1 = wr_stb && (wr_addr == OFS_THR1);
  wire wr_cur0 = wr_stb && (wr_addr == OFS_CUR0) && setup_mode;
  wire wr_cur1 = wr_stb && (wr_addr == OFS_CUR1) && setup_mode;
  wire wr_guard = wr_stb && (wr_addr == OFS_GUARD);
  wire wr_addrpu = wr_stb && (wr_addr == OFS_ADDRPU) && !bus_address_locked;
  wire wr_rbsel = wr_stb && (wr_addr == OFS_RBSEL);
  wire wr_cmd = wr_stb && (wr_addr == OFS_CMD);

  wire [7:0] cur_value = (wr_byte == ZERO_BYTE) ? CUR_ZERO_SUB : wr_byte;

  wire [7:0] unlock_exp = (unlock_stage == 2'h0) ? UNLOCK_B0 :
                          (unlock_stage == 2'h1) ? UNLOCK_B1 : UNLOCK_B2;
  wire unlock_match = (wr_byte == unlock_exp);
  wire unlock_hit = wr_guard && unlock_match && (unlock_stage == SEQ_LAST);
  wire [1:0] next_unlock_stage = unlock_hit ? 2'h0 :
                                 unlock_match ? unlock_stage + 2'h1 :
                                 (wr_byte == UNLOCK_B0) ? 2'h1 : 2'h0;
  wire [7:0] lock_exp = (lock_stage == 2'h0) ? LOCK_B0 :
                        (lock_stage == 2'h1) ? LOCK_B1 : LOCK_B2;
  wire lock_match = (wr_byte == lock_exp);
  wire lock_hit = wr_guard && lock_match && (lock_stage == SEQ_LAST);
  wire [1:0] next_lock_stage = lock_hit ? 2'h0 :
                               lock_match ? lock_stage + 2'h1 :
                               (wr_byte == LOCK_B0) ? 2'h1 : 2'h0;

  wire rb_onehot = wr_byte[1] ^ wr_byte[0];
  // target must be a touch input
  wire rb_is_touch = ((wr_byte[1:0] & ~touch_input_mask) == 2'h0);
  wire rb_accept = wr_rbsel && rb_onehot && rb_is_touch;

  // ****************************************
  // Read selection
  // ****************************************
  wire rb_idx = readback_select[1];
  wire rb_on = readback_select[2];
  wire [15:0] base_word = rb_on ? baseline_value[rb_idx] : 16'h0000;
  wire [15:0] delta_word = rb_on ? delta_count[rb_idx] : 16'h0000;
  wire [15:0] raw_word = rb_on ? raw_count[rb_idx] : 16'h0000;
  // supply range, internal reset, factory load
  wire [7:0] status_byte = {supply_range, internal_reset_flag, factory_config_loaded,
                            supply_too_low_for_store, 1'b0, touch_function_on,
                            output_function_on};
  wire [7:0] touch_byte = {6'h00, touch_detected};

  wire [7:0] rd_data =
    (ptr == OFS_FILTER) ? filter_ctrl :
    (ptr == OFS_SCAN0) ? {7'h00, scan_order_sensor0} :
    (ptr == OFS_SCAN1) ? {7'h00, scan_order_sensor1} :
    (ptr == OFS_THR0) ? touch_threshold_sensor0 :
    (ptr == OFS_THR1) ? touch_threshold_sensor1 :
    (ptr == OFS_CUR0) ? sense_current_sensor0 :
    (ptr == OFS_CUR1) ? sense_current_sensor1 :
    (ptr == OFS_GUARD) ? {7'h00, bus_address_locked} :
    (ptr == OFS_IDENT) ? PART_ID :
    (ptr == OFS_STATUS) ? status_byte :
    (ptr == OFS_ADDRPU) ? addr_pending :
    (ptr == OFS_RBSEL) ? {readback_select[2], 5'h00, readback_select[1:0]} :
    (ptr == OFS_BASE_HI) ? base_word[15:8] :
    (ptr == OFS_BASE_LO) ? base_word[7:0] :
    (ptr == OFS_DELTA_HI) ? delta_word[15:8] :
    (ptr == OFS_DELTA_LO) ? delta_word[7:0] :
    (ptr == OFS_RAW_HI) ? raw_word[15:8] :
    (ptr == OFS_RAW_LO) ? raw_word[7:0] :
    (ptr == OFS_TOUCH) ? touch_byte : ZERO_BYTE;

  // ****************************************
  // Serial slave
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txbyte <= 8'h00;
      ptr <= 8'h00;
      wr_addr <= 8'h00;
      wr_byte <= 8'h00;
      wr_stb <= 1'b0;
      rw <= 1'b0;
      first_byte <= 1'b0;
      master_ack <= 1'b0;
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
      bus_active <= 1'b0;
    end
    else
    begin
      wr_stb <= 1'b0;
      sda_o <= 1'b0;
      if (bus_start)
      begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
        bus_active <= 1'b1;
      end
      else if (bus_stop)
      begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        bus_active <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (state == ST_RACK)
          master_ack <= ~sda_s2;
        else
        begin
          shreg <= {shreg[6:0], sda_s2};
          bitcnt <= bitcnt + 4'h1;
        end
      end
      else if (scl_fall)
      begin
        unique case (state)
          ST_IDLE:
            sda_oe <= 1'b0;
          ST_ADDR:
            if (bitcnt == BYTE_BITS)
            begin
              if (shreg[7:1] == bus_address)
              begin
                rw <= shreg[0];
                sda_oe <= 1'b1;
                state <= ST_ACK_A;
              end
              else
                state <= ST_IDLE;
            end
          ST_ACK_A:
            if (rw)
            begin
              sda_oe <= ~rd_data[7];
              txbyte <= {rd_data[6:0], 1'b0};
              ptr <= ptr + 8'h01;
              bitcnt <= 4'h0;
              state <= ST_RD;
            end
            else
            begin
              sda_oe <= 1'b0;
              bitcnt <= 4'h0;
              first_byte <= 1'b1;
              state <= ST_WR;
            end
          ST_WR:
            if (bitcnt == BYTE_BITS)
            begin
              sda_oe <= 1'b1;
              state <= ST_ACK_W;
              first_byte <= 1'b0;
              if (first_byte)
                ptr <= shreg;
              else
              begin
                // every byte is acked, read-only targets decode to nothing
                wr_stb <= 1'b1;
                wr_addr <= ptr;
                wr_byte <= shreg;
                ptr <= ptr + 8'h01;
              end
            end
          ST_ACK_W:
          begin
            sda_oe <= 1'b0;
            bitcnt <= 4'h0;
            state <= ST_WR;
          end
          ST_RD:
            if (bitcnt == BYTE_BITS)
            begin
              sda_oe <= 1'b0;
              state <= ST_RACK;
            end
            else
            begin
              sda_oe <= ~txbyte[7];
              txbyte <= {txbyte[6:0], 1'b0};
            end
          ST_RACK:
            if (master_ack)
            begin
              sda_oe <= ~rd_data[7];
              txbyte <= {rd_data[6:0], 1'b0};
              ptr <= ptr + 8'h01;
              bitcnt <= 4'h0;
              state <= ST_RD;
            end
            else
              state <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      filter_ctrl <= RST_FILTER;
      force_baseline_clear <= 1'b0;
      scan_order_sensor0 <= RST_SCAN0;
      scan_order_sensor1 <= RST_SCAN1;
      touch_threshold_sensor0 <= RST_THR;
      touch_threshold_sensor1 <= RST_THR;
      sense_current_sensor0 <= RST_CUR;
      sense_current_sensor1 <= RST_CUR;
      setup_mode <= 1'b0;
      readback_select <= 3'h0;
    end
    else
    begin
      if (wr_filter)
        filter_ctrl <= wr_byte & FILT_WR_MASK;
      else if (filter_ctrl[FILT_CLR_BIT])
        filter_ctrl[FILT_CLR_BIT] <= 1'b0;
      force_baseline_clear <= filter_ctrl[FILT_CLR_BIT] & ~wr_filter;
      if (wr_scan0)
        scan_order_sensor0 <= wr_byte[0];
      if (wr_scan1)
        scan_order_sensor1 <= wr_byte[0];
      if (wr_thr0)
        touch_threshold_sensor0 <= wr_byte;
      if (wr_thr1)
        touch_threshold_sensor1 <= wr_byte;
      if (wr_cur0)
        sense_current_sensor0 <= cur_value;
      if (wr_cur1)
        sense_current_sensor1 <= cur_value;
      if (wr_cmd && (wr_byte == CMD_SETUP))
        setup_mode <= 1'b1;
      else if (wr_cmd && (wr_byte == CMD_NORMAL))
        setup_mode <= 1'b0;
      if (rb_accept)
        readback_select <= {wr_byte[RB_EN_BIT], wr_byte[1:0]};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      avg_enable <= RST_FILTER[FILT_AVG_BIT];
      avg_order <= RST_FILTER[1:0];
      bus_busy_sample_drop <= RST_FILTER[FILT_DROP_BIT];
    end
    else
    begin
      avg_enable <= filter_ctrl[FILT_AVG_BIT];
      avg_order <= filter_ctrl[1:0];
      bus_busy_sample_drop <= filter_ctrl[FILT_DROP_BIT];
    end
  end

  // ****************************************
  // Bus-busy sample drop
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      busy_seen <= 1'b0;
      sample_discard <= 1'b0;
    end
    else
    begin
      busy_seen <= (scan_active & bus_active) | (busy_seen & ~scan_done);
      sample_discard <= scan_done & filter_ctrl[FILT_DROP_BIT] & (busy_seen | bus_active);
    end
  end

  // ****************************************
  // Address guard
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      unlock_stage <= 2'h0;
      lock_stage <= 2'h0;
      bus_address_locked <= RST_LOCKED;
      addr_pending <= RST_ADDRPU;
      bus_address <= RST_ADDRPU[6:0];
      pullup_disable <= RST_ADDRPU[PULLUP_BIT];
    end
    else
    begin
      if (wr_guard)
      begin
        unlock_stage <= next_unlock_stage;
        lock_stage <= next_lock_stage;
      end
      if (unlock_hit)
        bus_address_locked <= 1'b0;
      else if (lock_hit)
      begin
        bus_address_locked <= 1'b1;
        bus_address <= addr_pending[6:0];
        pullup_disable <= addr_pending[PULLUP_BIT];
      end
      if (wr_addrpu)
        addr_pending <= wr_byte;
    end
  end

endmodule

`default_nettype wire

// [tsc_regs_chk.sv]
// Port checks for the touch sensor register bank
`timescale 1ns/1ps
`default_nettype none
module tsc_regs_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scan_done,
  input wire logic bus_active,
  input wire logic sample_discard,
  input wire logic bus_busy_sample_drop,
  input wire logic force_baseline_clear,
  input wire logic scan_order_sensor0,
  input wire logic scan_order_sensor1,
  input wire logic [7:0] sense_current_sensor0,
  input wire logic [7:0] sense_current_sensor1,
  input wire logic [6:0] bus_address,
  input wire logic pullup_disable,
  input wire logic setup_mode
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_busy_end;
    scan_done && bus_active && bus_busy_sample_drop;
  endsequence
  sequence s_pulse;
    force_baseline_clear ##1 !force_baseline_clear;
  endsequence
  property p_clr_src;
    force_baseline_clear |-> $past(bus_active, 2);
  endproperty
  a_clr_src: assert property (p_clr_src)
    else $error("clear pulse without bus write");
  property p_clr_one;
    force_baseline_clear |-> s_pulse;
  endproperty
  a_clr_one: assert property (p_clr_one)
    else $error("clear pulse too long");
  property p_drop;
    s_busy_end |=> sample_discard;
  endproperty
  a_drop: assert property (p_drop)
    else $error("busy scan not discarded");
  property p_nodrop;
    scan_done && !bus_busy_sample_drop |=> !sample_discard;
  endproperty
  a_nodrop: assert property (p_nodrop)
    else $error("scan discarded with drop off");
  property p_cur_nz;
    sense_current_sensor0 != 8'h00 && sense_current_sensor1 != 8'h00;
  endproperty
  a_cur_nz: assert property (p_cur_nz)
    else $error("current setting zero");
  property p_setup_only;
    $changed(scan_order_sensor0) || $changed(scan_order_sensor1) ||
      $changed(sense_current_sensor0) || $changed(sense_current_sensor1) |-> $past(setup_mode);
  endproperty
  a_setup_only: assert property (p_setup_only)
    else $error("setup register changed in normal mode");
  property p_mode;
    $changed(setup_mode) |-> $past(bus_active);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode changed without command");
  property p_addr;
    $changed(bus_address) || $changed(pullup_disable) |-> $past(bus_active);
  endproperty
  a_addr: assert property (p_addr)
    else $error("address changed without lock write");
endmodule
bind tsc_regs tsc_regs_chk u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .scan_done(scan_done), .bus_active(bus_active),
  .sample_discard(sample_discard), .bus_busy_sample_drop(bus_busy_sample_drop),
  .force_baseline_clear(force_baseline_clear), .scan_order_sensor0(scan_order_sensor0),
  .scan_order_sensor1(scan_order_sensor1), .sense_current_sensor0(sense_current_sensor0),
  .sense_current_sensor1(sense_current_sensor1), .bus_address(bus_address),
  .pullup_disable(pullup_disable), .setup_mode(setup_mode)
);
`default_nettype wire

// [tsc_host.sv]
// Two-wire bus host model for the register bank
`timescale 1ns/1ps
`default_nettype none
module tsc_host (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  logic [6:0] dev = 7'h00;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick();
    repeat (10) @(posedge core_clk);
  endtask
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    tick();
    scl <= 1'b1;
    tick();
    r = sda_line;
    scl <= 1'b0;
    tick();
  endtask
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(last, a);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b0;
    tick();
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] v);
    logic [7:0] x;
    start();
    xfer({dev, 1'b0}, 1'b1, x);
    xfer(o, 1'b1, x);
    xfer(v, 1'b1, x);
    stop();
  endtask
  // Read ends with a not-acknowledge
  task automatic rd(input logic [7:0] o, output logic [7:0] v);
    logic [7:0] x;
    start();
    xfer({dev, 1'b0}, 1'b1, x);
    xfer(o, 1'b1, x);
    start();
    xfer({dev, 1'b1}, 1'b1, x);
    xfer(8'hff, 1'b1, v);
    stop();
  endtask
endmodule
`default_nettype wire

// [touch_sensor_config_regs_bench.sv]
// Self-checking bench for the touch sensor register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("FAIL %s expected %h seen %h", nm, e, g); \
    end \
  end
module touch_sensor_config_regs_bench;
  import tsc_pkg::*;
  // Arbitrary identity value
  localparam logic [7:0] ID = 8'h3e;
  localparam logic [7:0] ROFS [10] = '{OFS_FILTER, OFS_SCAN0, OFS_SCAN1, OFS_THR0, OFS_THR1,
    OFS_CUR0, OFS_CUR1, OFS_GUARD, OFS_ADDRPU, OFS_RBSEL};
  localparam logic [7:0] RVAL [10] = '{RST_FILTER, 8'h00, 8'h01, RST_THR, RST_THR, RST_CUR,
    RST_CUR, 8'h00, RST_ADDRPU, 8'h00};
  int bad_count = 0;
  int checked = 0;
  int n_clr = 0;
  int n_disc = 0;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl_i, sda_i, sda_o, sda_oe, sda_low;
  logic [1:0] touch_input_mask = 2'b01;
  logic [1:0][15:0] baseline_value = {16'h4321, 16'h1234};
  logic [1:0][15:0] delta_count = {16'h8765, 16'h0056};
  logic [1:0][15:0] raw_count = {16'h2468, 16'hab0c};
  logic [1:0] touch_detected = 2'b10;
  logic [6:0] st = 7'h56;
  logic scan_active = 1'b0;
  logic scan_done = 1'b0;
  logic sample_discard, force_baseline_clear, bus_busy_sample_drop, avg_enable;
  logic scan_order_sensor0, scan_order_sensor1, pullup_disable, setup_mode, bus_active;
  logic [1:0] avg_order;
  logic [7:0] touch_threshold_sensor0, touch_threshold_sensor1, d;
  logic [7:0] sense_current_sensor0, sense_current_sensor1;
  logic [6:0] bus_address;
  always #2.5 core_clk = ~core_clk;
  assign sda_i = !(sda_low || (sda_oe && !sda_o));
  tsc_host host (.core_clk, .sda_line(sda_i), .scl(scl_i), .sda_low);
  tsc_regs #(.PART_ID(ID)) dut (.core_clk, .rst_n, .scl_i, .sda_i, .sda_o, .sda_oe,
    .touch_input_mask, .baseline_value, .delta_count, .raw_count, .touch_detected,
    .supply_range(st[6:5]), .internal_reset_flag(st[4]), .factory_config_loaded(st[3]),
    .supply_too_low_for_store(st[2]), .touch_function_on(st[1]), .output_function_on(st[0]),
    .scan_active, .scan_done, .sample_discard, .force_baseline_clear, .bus_busy_sample_drop,
    .avg_enable, .avg_order, .scan_order_sensor0, .scan_order_sensor1, .touch_threshold_sensor0,
    .touch_threshold_sensor1, .sense_current_sensor0, .sense_current_sensor1, .bus_address,
    .pullup_disable, .setup_mode, .bus_active);
  always @(posedge core_clk)
  begin
    n_clr += int'(force_baseline_clear === 1'b1);
    n_disc += int'(sample_discard === 1'b1);
  end
  task automatic give_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] o, input logic [7:0] e);
    logic [7:0] v;
    host.rd(o, v);
    `CHK($sformatf("reg %h", o), e, v)
  endtask
  task automatic rb(input logic [7:0] o, input logic [15:0] v);
    rd_chk(o, v[15:8]);
    rd_chk(o + 8'h01, v[7:0]);
  endtask
  task automatic guard(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    host.wr(OFS_GUARD, a);
    host.wr(OFS_GUARD, b);
    host.wr(OFS_GUARD, c);
  endtask
  task automatic scan(input int w);
    repeat (w) @(posedge core_clk);
    scan_done <= 1'b1;
    scan_active <= 1'b0;
    @(posedge core_clk);
    scan_done <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  initial
  begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 10; i++)
      rd_chk(ROFS[i], RVAL[i]);
    `CHK("idle", 1'b0, bus_active)
    `CHK("scan1", RST_SCAN1, scan_order_sensor1)
    `CHK("thr1", RST_THR, touch_threshold_sensor1)
    host.wr(OFS_CUR0, 8'h33);
    host.wr(OFS_THR0, 8'h03);
    host.wr(OFS_THR1, 8'hff);
    `CHK("cur0", RST_CUR, sense_current_sensor0)
    `CHK("thr0", 8'h03, touch_threshold_sensor0)
    `CHK("thr1", 8'hff, touch_threshold_sensor1)
    host.wr(OFS_CMD, CMD_SETUP);
    `CHK("mode", 1'b1, setup_mode)
    host.wr(OFS_CUR0, 8'h44);
    `CHK("cur0", 8'h44, sense_current_sensor0)
    host.wr(OFS_CUR0, ZERO_BYTE);
    host.wr(OFS_CUR1, 8'h33);
    host.wr(OFS_SCAN0, 8'h01);
    host.wr(OFS_SCAN1, 8'h00);
    host.wr(OFS_CMD, CMD_NORMAL);
    host.wr(OFS_SCAN1, 8'h01);
    `CHK("cur0", CUR_ZERO_SUB, sense_current_sensor0)
    `CHK("cur1", 8'h33, sense_current_sensor1)
    `CHK("scan0", 1'b1, scan_order_sensor0)
    `CHK("scan1", 1'b0, scan_order_sensor1)
    `CHK("mode", 1'b0, setup_mode)
    for (int c = 0; c < 4; c++)
    begin
      host.wr(OFS_FILTER, 8'h10 | 8'(c));
      `CHK("order", 2'(c), avg_order)
      `CHK("avg", 1'b1, avg_enable)
    end
    `CHK("clears", 0, n_clr)
    host.wr(OFS_FILTER, 8'h80);
    `CHK("clears", 1, n_clr)
    rd_chk(OFS_FILTER, 8'h00);
    host.wr(OFS_FILTER, 8'h20);
    `CHK("drop", 1'b1, bus_busy_sample_drop)
    scan_active <= 1'b1;
    fork
      host.rd(OFS_IDENT, d);
      scan(300);
    join
    `CHK("ident", ID, d)
    `CHK("discards", 1, n_disc)
    scan_active <= 1'b1;
    scan(20);
    host.wr(OFS_FILTER, 8'h00);
    scan_active <= 1'b1;
    fork
      host.rd(OFS_IDENT, d);
      scan(300);
    join
    `CHK("discards", 1, n_disc)
    rd_chk(OFS_GUARD, 8'h00);
    guard(LOCK_B0, LOCK_B1, LOCK_B2);
    rd_chk(OFS_GUARD, 8'h01);
    host.wr(OFS_ADDRPU, 8'h11);
    rd_chk(OFS_ADDRPU, 8'h00);
    guard(UNLOCK_B0, UNLOCK_B1, UNLOCK_B2);
    rd_chk(OFS_GUARD, 8'h00);
    host.wr(OFS_ADDRPU, 8'hc5);
    `CHK("addr", 7'h00, bus_address)
    guard(LOCK_B0, LOCK_B1, LOCK_B2);
    `CHK("addr", 7'h45, bus_address)
    `CHK("pullup", 1'b1, pullup_disable)
    host.dev = 7'h45;
    rd_chk(OFS_ADDRPU, 8'hc5);
    host.wr(OFS_RBSEL, 8'h81);
    host.wr(OFS_RBSEL, 8'h82);
    host.wr(OFS_RBSEL, 8'h83);
    rd_chk(OFS_RBSEL, 8'h81);
    rb(OFS_BASE_HI, baseline_value[0]);
    rb(OFS_DELTA_HI, delta_count[0]);
    rb(OFS_RAW_HI, raw_count[0]);
    host.wr(OFS_RBSEL, 8'h01);
    rd_chk(OFS_BASE_HI, 8'h00);
    touch_input_mask <= 2'b11;
    host.wr(OFS_RBSEL, 8'h82);
    rb(OFS_BASE_HI, baseline_value[1]);
    rd_chk(OFS_TOUCH, {6'h00, touch_detected});
    for (int k = 0; k < 2; k++)
    begin
      st <= st ^ 7'h7f;
      host.wr(OFS_STATUS, 8'hff);
      host.wr(OFS_IDENT, 8'h00);
      rd_chk(OFS_STATUS, {st[6:2], 1'b0, st[1:0]});
      rd_chk(OFS_IDENT, ID);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
